// ### design/phy_sata_report.sv
// Phy SATA report response framer with initial FIS capture and APB registers.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module phy_sata_report #(
    parameter int PHY_ID_W = 8
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Request byte stream
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_data,
    input  wire logic        req_last,
    // Response byte stream
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_last,
    input  wire logic        rsp_ready,
    // Phy state and FIS capture
    input  wire logic        sync_loss_cominit,
    input  wire logic        fis_valid,
    input  wire logic [7:0]  fis_data,
    input  wire logic        fis_last,
    input  wire logic        fis_error,
    // Bridge status
    output logic             retry_r_err,
    input  wire logic        open_req,
    output logic             open_reject_no_dest,
    output logic             disc_attached_sata,
    output logic [2:0]       disc_attached_type
);
    typedef enum logic [1:0] {S_IDLE, S_RECV, S_SEND, S_DROP} state_t;
    // Attached type shown once the initial FIS is in; the value is a local choice.
    localparam logic [2:0] DEV_TYPE_SATA = 3'h5;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [31:0] ctrl_q, ctrl_d;
    logic [63:0] stp_addr_q, stp_addr_d;
    logic [63:0] init_addr_q, init_addr_d;
    logic [7:0]  result_q, result_d;
    logic [7:0]  fis_q [phy_sata_report_pkg::FIS_LEN];
    logic [7:0]  fis_d [phy_sata_report_pkg::FIS_LEN];
    logic [7:0]  fis_buf_q [phy_sata_report_pkg::FIS_LEN];
    logic [7:0]  fis_buf_d [phy_sata_report_pkg::FIS_LEN];
    logic [4:0]  fis_cnt_q, fis_cnt_d;
    logic        fis_ok_q, fis_ok_d;
    logic        retry_q, retry_d;
    state_t      state_q, state_d;
    logic [5:0]  idx_q, idx_d;
    logic        req_ok_q, req_ok_d;
    logic [PHY_ID_W-1:0] phy_q, phy_d;
    logic [7:0]  rsp_q, rsp_d;
    logic        reject_q, reject_d;
    logic        apb_wr;
    logic [31:0] status_word;

    assign apb_wr = psel && penable && pwrite;

    // ==========================================================
    // Response byte selection
    // ==========================================================
    function automatic logic [7:0] addr_byte(input logic [63:0] a, input int k);
        addr_byte = a[(phy_sata_report_pkg::ADDR_LEN-1-k)*8 +: 8];
    endfunction

    function automatic logic in_range(input int n, input int base, input int len);
        in_range = (n >= base) && (n < base + len);
    endfunction

    function automatic logic [7:0] rsp_byte(input logic [5:0] i);
        int n;
        n = int'(i);
        rsp_byte = 8'h00; // R20
        if (n == phy_sata_report_pkg::BYTE_FTYPE) begin
            rsp_byte = phy_sata_report_pkg::RSP_FRAME_TYPE; // R1
        end else if (n == phy_sata_report_pkg::BYTE_FUNC) begin
            rsp_byte = phy_sata_report_pkg::FUNC_PHY_SATA; // R2
        end else if (n == phy_sata_report_pkg::BYTE_RESULT) begin
            rsp_byte = result_q;
        end else if (n == phy_sata_report_pkg::BYTE_PHY_ID) begin
            rsp_byte = 8'(phy_q); // R3
        end else if (n == phy_sata_report_pkg::BYTE_AFFIL) begin
            rsp_byte[phy_sata_report_pkg::BIT_AFFIL_SUP] = ctrl_q[phy_sata_report_pkg::CTRL_AFFIL_SUP]; // R4
            rsp_byte[phy_sata_report_pkg::BIT_AFFIL_VALID] = ctrl_q[phy_sata_report_pkg::CTRL_AFFIL_ACT]
                && ctrl_q[phy_sata_report_pkg::CTRL_INIT_VALID]; // R5 R6
        end else if (in_range(n, phy_sata_report_pkg::BYTE_STP_ADDR, phy_sata_report_pkg::ADDR_LEN)) begin
            rsp_byte = addr_byte(stp_addr_q, n - phy_sata_report_pkg::BYTE_STP_ADDR); // R7
        end else if (in_range(n, phy_sata_report_pkg::BYTE_FIS, phy_sata_report_pkg::FIS_LEN)) begin
            rsp_byte = fis_q[n - phy_sata_report_pkg::BYTE_FIS]; // R8 R9
        end else if (in_range(n, phy_sata_report_pkg::BYTE_INIT_ADDR, phy_sata_report_pkg::ADDR_LEN)) begin
            rsp_byte = addr_byte(init_addr_q, n - phy_sata_report_pkg::BYTE_INIT_ADDR); // R16
        end
    endfunction

    // ==========================================================
    // APB and configuration
    // ==========================================================
    always_comb begin
        ctrl_d      = ctrl_q;
        stp_addr_d  = stp_addr_q;
        init_addr_d = init_addr_q;
        result_d    = result_q;
        // Writes to read-only or unmapped offsets are dropped; pslverr flags the unmapped ones.
        if (apb_wr) begin
            unique case (paddr)
                phy_sata_report_pkg::REG_CTRL:         ctrl_d = pwdata;
                phy_sata_report_pkg::REG_STP_ADDR_LO:  stp_addr_d[31:0] = pwdata;
                phy_sata_report_pkg::REG_STP_ADDR_HI:  stp_addr_d[63:32] = pwdata;
                phy_sata_report_pkg::REG_INIT_ADDR_LO: init_addr_d[31:0] = pwdata;
                phy_sata_report_pkg::REG_INIT_ADDR_HI: init_addr_d[63:32] = pwdata;
                phy_sata_report_pkg::REG_RESULT:       result_d = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        unique case (paddr)
            phy_sata_report_pkg::REG_CTRL:         prdata = ctrl_q;
            phy_sata_report_pkg::REG_STATUS:       prdata = status_word;
            phy_sata_report_pkg::REG_STP_ADDR_LO:  prdata = stp_addr_q[31:0];
            phy_sata_report_pkg::REG_STP_ADDR_HI:  prdata = stp_addr_q[63:32];
            phy_sata_report_pkg::REG_INIT_ADDR_LO: prdata = init_addr_q[31:0];
            phy_sata_report_pkg::REG_INIT_ADDR_HI: prdata = init_addr_q[63:32];
            phy_sata_report_pkg::REG_RESULT:       prdata = {24'h0, result_q};
            default:                               pslverr = psel && penable;
        endcase
    end
    // Every register answers in its first access cycle, so the bus never waits.
    assign pready      = 1'b1;
    assign status_word = {30'h0, retry_q, fis_ok_q};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q      <= 32'h0;
            stp_addr_q  <= 64'h0;
            init_addr_q <= 64'h0;
            result_q    <= phy_sata_report_pkg::RESULT_RESET;
        end else begin
            ctrl_q      <= ctrl_d;
            stp_addr_q  <= stp_addr_d;
            init_addr_q <= init_addr_d;
            result_q    <= result_d;
        end
    end

    // ==========================================================
    // Initial FIS capture
    // ==========================================================
    always_comb begin
        fis_d     = fis_q;
        fis_buf_d = fis_buf_q;
        fis_cnt_d = fis_cnt_q;
        fis_ok_d  = fis_ok_q;
        retry_d   = 1'b0;
        // A native target has its FIS supplied directly, so it always counts as delivered.
        if (ctrl_q[phy_sata_report_pkg::CTRL_NATIVE]) begin
            fis_ok_d = 1'b1;
            fis_d[0] = phy_sata_report_pkg::FIS_TYPE_REG_D2H;
        end
        // Bytes collect in a shadow buffer so a failed FIS never disturbs the stored one.
        if (fis_valid) begin
            if (fis_error) begin
                retry_d   = 1'b1; // R14
                fis_cnt_d = 5'h0;
            end else begin
                if (int'(fis_cnt_q) < phy_sata_report_pkg::FIS_LEN) begin
                    fis_buf_d[fis_cnt_q] = fis_data; // R9
                    fis_cnt_d = fis_cnt_q + 5'h1;
                end
                if (fis_last) begin
                    fis_cnt_d = 5'h0;
                    if (fis_buf_d[0] == phy_sata_report_pkg::FIS_TYPE_REG_D2H) begin
                        fis_d    = fis_buf_d; // R12
                        fis_d[0] = phy_sata_report_pkg::FIS_TYPE_REG_D2H; // R11
                        fis_ok_d = 1'b1;
                    end else begin
                        retry_d = 1'b1; // R14
                    end
                end
            end
        end
        // Sync loss comes last so that it wins over a FIS ending in the same cycle.
        if (sync_loss_cominit && !ctrl_q[phy_sata_report_pkg::CTRL_NATIVE]) begin
            fis_d[0]  = phy_sata_report_pkg::FIS_TYPE_INVALID; // R10
            fis_ok_d  = 1'b0;
            fis_cnt_d = 5'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < phy_sata_report_pkg::FIS_LEN; i++) begin
                fis_q[i]     <= phy_sata_report_pkg::FIS_TYPE_INVALID; // R10
                fis_buf_q[i] <= 8'h0;
            end
            fis_cnt_q <= 5'h0;
            fis_ok_q  <= 1'b0;
            retry_q   <= 1'b0;
            reject_q  <= 1'b0;
        end else begin
            fis_q     <= fis_d;
            fis_buf_q <= fis_buf_d;
            fis_cnt_q <= fis_cnt_d;
            fis_ok_q  <= fis_ok_d;
            retry_q   <= retry_d;
            reject_q  <= reject_d;
        end
    end

    // ==========================================================
    // Bridge status
    // ==========================================================
    // The reject is registered so that it never glitches while the FIS flag settles.
    assign reject_d            = open_req && !fis_ok_q; // R13
    assign open_reject_no_dest = reject_q;
    assign retry_r_err         = retry_q;
    assign disc_attached_sata  = 1'b1; // R15
    assign disc_attached_type  = fis_ok_q ? DEV_TYPE_SATA : phy_sata_report_pkg::DEV_TYPE_NONE; // R15

    // ==========================================================
    // Request parse and response send
    // ==========================================================
    always_comb begin
        state_d  = state_q;
        idx_d    = idx_q;
        req_ok_d = req_ok_q;
        phy_d    = phy_q;
        rsp_d    = rsp_q;
        unique case (state_q)
            S_IDLE, S_RECV: begin
                if (req_valid) begin
                    state_d = S_RECV;
                    idx_d   = idx_q + 6'h1;
                    if (int'(idx_q) == phy_sata_report_pkg::BYTE_FTYPE) begin
                        req_ok_d = (req_data == phy_sata_report_pkg::REQ_FRAME_TYPE); // R18
                    end else if (int'(idx_q) == phy_sata_report_pkg::BYTE_FUNC) begin
                        req_ok_d = req_ok_q && (req_data == phy_sata_report_pkg::FUNC_PHY_SATA); // R18
                    end else if (int'(idx_q) == phy_sata_report_pkg::BYTE_PHY_ID) begin
                        phy_d = req_data[PHY_ID_W-1:0];
                    end
                    // Bytes after the phy identifier, the CRC among them, are not checked here.
                    if (req_last) begin
                        idx_d = 6'h0;
                        // Only an enabled port answers; others stay silent. R19
                        if (req_ok_d && ctrl_q[phy_sata_report_pkg::CTRL_ENABLE]) begin
                            state_d = S_SEND;
                        end else begin
                            state_d = S_IDLE;
                        end
                    end
                end
            end
            S_SEND: begin
                if (rsp_ready) begin
                    if (int'(idx_q) == phy_sata_report_pkg::BYTE_CRC - 1) begin
                        // The CRC bytes are appended downstream. R17
                        idx_d   = 6'h0;
                        state_d = S_IDLE;
                    end else begin
                        idx_d = idx_q + 6'h1;
                    end
                end
            end
            // Unused code; it falls back to idle so that an upset cannot lock the framer.
            S_DROP: state_d = S_IDLE;
        endcase
        // The byte for the next index is loaded now so that rsp_data comes from a flop.
        rsp_d = rsp_byte(idx_d);
    end

    assign rsp_valid = (state_q == S_SEND);
    assign rsp_data  = rsp_q;
    assign rsp_last  = rsp_valid && int'(idx_q) == phy_sata_report_pkg::BYTE_CRC - 1;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q  <= S_IDLE;
            idx_q    <= 6'h0;
            req_ok_q <= 1'b0;
            phy_q    <= '0;
            rsp_q    <= 8'h0;
        end else begin
            state_q  <= state_d;
            idx_q    <= idx_d;
            req_ok_q <= req_ok_d;
            phy_q    <= phy_d;
            rsp_q    <= rsp_d;
        end
    end
endmodule

// ### design/phy_sata_report_pkg.sv
// Constants for the phy SATA report response framer.
// What this block does
// R1: Response byte 0 carries the response frame type code 41h.
// R2: Response byte 1 carries function code 12h.
// R3: Response byte 9 echoes the identifier of the reported phy.
// R4: Byte 11 bit 1 shows whether the target port supports affiliations.
// R5: Affiliation-valid is one while an affiliation exists with a valid address.
// R6: Affiliation-valid is zero while no affiliation is maintained.
// R7: Bytes 16 to 23 carry the STP target port SAS address.
// R8: Bytes 24 to 43 carry the captured initial register FIS.
// R9: The FIS is stored little-endian; its type byte lands in byte 24.
// R10: The stored FIS type clears at reset and on sync loss to COMINIT; with CTRL_NATIVE set, sync loss is ignored and the type stays 34h.
// R11: The FIS type becomes 34h once the initial FIS is delivered.
// R12: Other FIS bytes stay unchanged until another initial FIS arrives.
// R13: Connections to a device without its initial FIS are rejected, no destination.
// R14: A failed initial FIS reception is retried with an R_ERR until success.
// R15: While FIS is pending, discovery reports attached device type none.
// R16: Bytes 48 to 55 carry the affiliated STP initiator SAS address.
// R17: Bytes 56 to 59 carry the CRC, supplied by the external CRC engine.
// R18: The requester sends frame type 40h, function 12h, phy in byte 9.
// R19: Only ports bound to an STP target or bridge implement this function.
// R20: Reserved bytes and unused bits of byte 11 are sent as zero.
package phy_sata_report_pkg;
    localparam logic [7:0] REQ_FRAME_TYPE    = 8'h40;
    localparam logic [7:0] RSP_FRAME_TYPE    = 8'h41;
    localparam logic [7:0] FUNC_PHY_SATA     = 8'h12;
    localparam logic [7:0] FIS_TYPE_REG_D2H  = 8'h34;
    localparam logic [7:0] FIS_TYPE_INVALID  = 8'h00;
    localparam logic [2:0] DEV_TYPE_NONE     = 3'h0;
    localparam int         REQ_LEN           = 16;
    localparam int         RSP_LEN           = 60;
    localparam int         BYTE_FTYPE        = 0;
    localparam int         BYTE_FUNC         = 1;
    localparam int         BYTE_RESULT       = 2;
    localparam int         BYTE_PHY_ID       = 9;
    localparam int         BYTE_AFFIL        = 11;
    localparam int         BIT_AFFIL_SUP     = 1;
    localparam int         BIT_AFFIL_VALID   = 0;
    localparam int         BYTE_STP_ADDR     = 16;
    localparam int         BYTE_FIS          = 24;
    localparam int         FIS_LEN           = 20;
    localparam int         BYTE_INIT_ADDR    = 48;
    localparam int         BYTE_CRC          = 56;
    localparam int         ADDR_LEN          = 8;
    localparam int         CRC_LEN           = 4;
    // APB register byte addresses.
    localparam logic [7:0] REG_CTRL          = 8'h00;
    localparam logic [7:0] REG_STATUS        = 8'h04;
    localparam logic [7:0] REG_STP_ADDR_LO   = 8'h08;
    localparam logic [7:0] REG_STP_ADDR_HI   = 8'h0c;
    localparam logic [7:0] REG_INIT_ADDR_LO  = 8'h10;
    localparam logic [7:0] REG_INIT_ADDR_HI  = 8'h14;
    localparam logic [7:0] REG_RESULT        = 8'h18;
    localparam int         CTRL_ENABLE       = 0;
    localparam int         CTRL_AFFIL_SUP    = 1;
    localparam int         CTRL_AFFIL_ACT    = 2;
    localparam int         CTRL_INIT_VALID   = 3;
    localparam int         CTRL_NATIVE       = 4;
    localparam logic [7:0] RESULT_RESET      = 8'h00;
endpackage

// ### test/phy_sata_report_chk.sv
// Port-level assertions for the phy SATA report response framer.
`timescale 1ns/1ns
module phy_sata_report_chk (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rstn,
    // APB and streams
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pslverr,
    input wire logic       req_valid,
    input wire logic       req_last,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_last,
    input wire logic       rsp_ready,
    // Phy and bridge status
    input wire logic       fis_valid,
    input wire logic       fis_error,
    input wire logic       retry_r_err,
    input wire logic       open_req,
    input wire logic       open_reject_no_dest,
    input wire logic       disc_attached_sata,
    input wire logic [2:0] disc_attached_type
);
    // ==========================================
    // Byte position of the response stream.
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (rsp_valid && rsp_ready) begin
            cnt_d = rsp_last ? 6'h00 : cnt_q + 6'h01;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // ==========================================
    // Assertions.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    AST_FTYPE: assert property (rsp_valid && cnt_q == 6'h00 |-> rsp_data == 8'h41)
        else $error("byte 0 is not the response frame type");
    AST_FUNC: assert property (rsp_valid && cnt_q == 6'h01 |-> rsp_data == 8'h12)
        else $error("byte 1 is not the function code");
    AST_LAST: assert property (rsp_valid |-> (rsp_last == (cnt_q == 6'h37)))
        else $error("last flag not on byte 55");
    AST_RSVD: assert property (rsp_valid && (cnt_q inside {[3:8], 10, [12:15], [44:47]})
        |-> rsp_data == 8'h00) else $error("reserved byte not zero");
    AST_B11: assert property (rsp_valid && cnt_q == 6'h0b |-> rsp_data[7:2] == 6'h00)
        else $error("unused bits of byte 11 not zero");
    AST_FIS_TYPE: assert property (rsp_valid && cnt_q == 6'h18 |-> rsp_data inside {8'h00, 8'h34})
        else $error("stored FIS type neither invalid nor register code");
    AST_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
        else $error("response byte changed while stalled");
    AST_START: assert property ($rose(rsp_valid) |-> $past(req_valid && req_last))
        else $error("response started without a finished request");
    AST_REJECT: assert property (open_req && disc_attached_type == 3'h0 |=> open_reject_no_dest)
        else $error("open not rejected while FIS missing");
    AST_NO_REJ: assert property (!open_req |=> !open_reject_no_dest)
        else $error("reject without a connection request");
    AST_RETRY: assert property (fis_valid && fis_error |=> retry_r_err)
        else $error("no retry after a failed FIS");
    AST_SATA: assert property (disc_attached_sata)
        else $error("attached SATA flag low");
    AST_SLVERR: assert property (psel && penable && paddr == 8'h1c |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind phy_sata_report phy_sata_report_chk u_chk (.core_clk, .rstn, .psel, .penable, .paddr, .pslverr, .req_valid,
    .req_last, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready, .fis_valid, .fis_error, .retry_r_err, .open_req,
    .open_reject_no_dest, .disc_attached_sata, .disc_attached_type);

// ### test/phy_sata_report_initiator.sv
// Management initiator model: sends requests and collects response bytes.
`timescale 1ns/1ns
module phy_sata_report_initiator (
    // Clock
    input wire logic       core_clk,
    // Request stream
    output logic           req_valid,
    output logic [7:0]     req_data,
    output logic           req_last,
    // Response stream
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_last,
    output logic           rsp_ready
);
    logic [7:0] rx [0:63];
    int         n_rx = 0;
    logic       got_last = 1'b0;
    logic [2:0] stall = 3'h0;
    initial begin
        req_valid = 0;
        req_data  = 8'h00;
        req_last  = 0;
    end
    // Ready drops on some cycles so the framer must hold its bytes.
    always @(posedge core_clk) begin
        stall <= stall + 3'h1;
        rsp_ready <= (stall != 3'h2) && (stall != 3'h5);
        // A new request clears what the last response left behind.
        if (req_valid) begin
            n_rx <= 0;
            got_last <= 1'b0;
        end else if (rsp_valid && rsp_ready) begin
            rx[n_rx[5:0]] <= rsp_data;
            n_rx <= n_rx + 1;
            got_last <= rsp_last;
        end
    end
    task automatic xfer(input logic [7:0] ft, input logic [7:0] fn, input logic [7:0] phy);
        int i;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            req_valid <= 1;
            req_data  <= (i == 0) ? ft : (i == 1) ? fn : (i == 9) ? phy : 8'h00;
            req_last  <= (i == 15);
        end
        @(posedge core_clk);
        req_valid <= 0;
        req_last  <= 0;
        req_data  <= ~req_data;
        for (i = 0; i < 200 && got_last !== 1; i++) begin
            @(posedge core_clk);
        end
    endtask
endmodule

// ### test/phy_sata_report_bench.sv
// Self-checking bench for the phy SATA report response framer.
`timescale 1ns/1ns
module phy_sata_report_bench;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00, req_data, rsp_data, fis_data = 8'h00, phy, res, ftype;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic req_valid, req_last, rsp_valid, rsp_last, rsp_ready, retry_r_err, open_reject_no_dest;
    logic sync_loss_cominit = 0, fis_valid = 0, fis_last = 0, fis_error = 0, open_req = 0;
    logic disc_attached_sata, sv;
    logic [2:0] disc_attached_type;
    logic [3:0] ctl;
    logic [63:0] stp, ini;
    logic [7:0] fis [0:19];
    int n_mismatch = 0, n_tests = 0, seed = 61573, cyc = 0, i, k;
    always #5 core_clk = ~core_clk;
    phy_sata_report DUT (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .req_valid, .req_data, .req_last, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready, .sync_loss_cominit,
        .fis_valid, .fis_data, .fis_last, .fis_error, .retry_r_err, .open_req, .open_reject_no_dest,
        .disc_attached_sata, .disc_attached_type);
    phy_sata_report_initiator U (.core_clk, .req_valid, .req_data, .req_last, .rsp_valid, .rsp_data, .rsp_last,
        .rsp_ready);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // A hung handshake ends the run here.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1;
        // Only the cycle ceiling ends a wait for pready.
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        sv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [7:0] eb(int n);
        if (n == 0) return 8'h41;
        if (n == 1) return 8'h12;
        if (n == 2) return res;
        if (n == 9) return phy;
        if (n == 11) return {6'h00, ctl[1], ctl[2] & ctl[3]};
        if (n >= 16 && n <= 23) return stp[8 * (23 - n) +: 8];
        if (n == 24) return ftype;
        if (n >= 25 && n <= 43) return fis[n - 24];
        if (n >= 48 && n <= 55) return ini[8 * (55 - n) +: 8];
        return 8'h00;
    endfunction
    task automatic frame();
        phy = 8'($random(seed));
        U.xfer(8'h40, 8'h12, phy);
        chk("byte count", U.n_rx, 56);
        for (i = 0; i < 56; i++) chk("rsp byte", U.rx[i], eb(i));
    endtask
    task automatic fis_send(input logic err);
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            {fis_valid, fis_data, fis_last, fis_error} <= {1'b1, fis[i], i == 19, err && i == 19};
        end
        @(posedge core_clk);
        {fis_valid, fis_last, fis_error} <= 3'h0;
        #1 chk("retry", retry_r_err, err);
    endtask
    task automatic status(input logic got);
        repeat (2) @(posedge core_clk);
        #1 chk("reject", open_reject_no_dest, !got);
        chk("dev type", disc_attached_type, got ? 3'h5 : 3'h0);
        chk("sata", disc_attached_sata, 1);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1;
        apb(0, 8'h00, 0);
        chk("ctrl reset", rd, 0);
        apb(0, 8'h1c, 0);
        chk("unmapped", sv, 1);
        {stp, ini, res, ftype} = {$random(seed), $random(seed), $random(seed), $random(seed), 8'h00, 8'h00};
        res = 8'($random(seed));
        for (i = 0; i < 20; i++) fis[i] = 8'h00;
        apb(1, 8'h08, stp[31:0]);
        apb(1, 8'h0c, stp[63:32]);
        apb(1, 8'h10, ini[31:0]);
        apb(1, 8'h14, ini[63:32]);
        apb(1, 8'h18, {24'h0, res});
        apb(0, 8'h08, 0);
        chk("stp lo", rd, stp[31:0]);
        chk("slverr", sv, 0);
        open_req <= 1;
        status(0);
        // Every combination of the affiliation controls, before any FIS arrived.
        for (k = 0; k < 8; k++) begin
            ctl = {k[2:0], 1'b1};
            apb(1, 8'h00, {28'h0, ctl});
            frame();
        end
        // A failed FIS is retried, then a good one is captured.
        for (k = 0; k < 20; k++) fis[k] = (k == 0) ? 8'h34 : 8'($random(seed));
        fis_send(1);
        fis_send(0);
        ftype = 8'h34;
        status(1);
        frame();
        // Sync loss invalidates only the type byte.
        @(posedge core_clk) sync_loss_cominit <= 1;
        @(posedge core_clk) sync_loss_cominit <= 0;
        ftype = 8'h00;
        status(0);
        frame();
        // A native target has its FIS supplied, so sync loss leaves it delivered.
        ctl = 4'h1;
        apb(1, 8'h00, 32'h11);
        ftype = 8'h34;
        @(posedge core_clk) sync_loss_cominit <= 1;
        @(posedge core_clk) sync_loss_cominit <= 0;
        status(1);
        frame();
        // A request with a wrong frame type gets no answer.
        U.xfer(8'h41, 8'h12, 8'h00);
        chk("bad header", U.n_rx, 0);
        // Disabled framer stays silent too.
        apb(1, 8'h00, 32'h0);
        U.xfer(8'h40, 8'h12, 8'h00);
        chk("disabled", U.n_rx, 0);
        print_verdict();
    end
endmodule
